// ---- bench/isac_bus_master.sv ----
// Two-wire bus master model: drives the clock and pulls the data line low
`timescale 1ns/1ns
`default_nettype none
module isac_bus_master (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   // ==========================================
   // Idle bus: clock stands high, data released
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // One bit slot: 6 cycles low, 2 high, 800 ns
   task automatic bit_io(input logic b, output logic s);
      tick(2);
      o_sda_low <= ~b;
      tick(4);
      o_scl <= 1'b1;
      tick(2);
      s = i_sda;
      o_scl <= 1'b0;
   endtask

   // Data falls while clock high
   task automatic start();
      tick(1);
      o_sda_low <= 1'b0;
      tick(3);
      o_scl <= 1'b1;
      tick(3);
      o_sda_low <= 1'b1;
      tick(3);
      o_scl <= 1'b0;
   endtask

   // Data rises while clock high, clock then stands still
   task automatic stop();
      tick(2);
      o_sda_low <= 1'b1;
      tick(4);
      o_scl <= 1'b1;
      tick(3);
      o_sda_low <= 1'b0;
      tick(3);
   endtask

   // Eight bits MSB first plus the acknowledge slot
   task automatic xbyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ack_in, ack);
   endtask

   // One-cycle clock pulse inside a low phase, shorter than the line filter
   task automatic spike();
      o_scl <= 1'b1;
      tick(1);
      o_scl <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the two-wire converter controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb;
   import isac_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic scl, sda_low, sda, o_sda_out, o_sda_oe, comp, pwr, trk, ref_ext;
   logic [1:0] mux;
   logic [CODE_W-1:0] dac;
   logic [CODE_W-1:0] held = '0;
   logic [CODE_W-1:0] ain [4];
   logic scramble = 1'b0;
   logic [31:0] lfsr = 32'h2253_0830;
   logic [7:0] cfgs [6] = '{8'h40, 8'h30, 8'ha0, 8'h88, 8'h14, 8'hf8};
   int nw [6] = '{1, 2, 3, 1, 1, 3};
   int fail_count = 0;
   int tests_run = 0;
   int pw_cnt = 0;
   int trk_cnt = 0;
   int cfg = 8'hf0;
   int cur = 0;

   // ==========================================
   // Clock, open-drain wire and analog side
   always #50 i_clk = ~i_clk;
   assign sda = ~((o_sda_oe & ~o_sda_out) | sda_low);
   assign comp = (held >= dac);
   always @(posedge i_clk) begin
      if (trk) held <= ain[mux];
      if (!trk && scramble) ain[mux] <= ~held;
      if (pwr === 1'b1) pw_cnt++;
      if (trk === 1'b0) trk_cnt++;
   end

   isac_top #(.VARIANT(1'b1), .STABLE(FILT_CYC)) isac_top_inst (
      .i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .i_sda_in(sda), .o_sda_out(o_sda_out),
      .o_sda_oe(o_sda_oe), .i_comp_high(comp), .o_adc_power_on(pwr), .o_track(trk),
      .o_mux_sel(mux), .o_ref_ext(ref_ext), .o_dac_code(dac));

   isac_bus_master isac_bus_master_inst (
      .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

   // ==========================================
   // Reference model helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic int pick(input int c, input int from);
      int m;
      m = (c >> 4) & (((c & 8) != 0) ? 7 : 15);
      if (m == 0) return 0;
      for (int k = 0; k < 4; k++) if ((m >> ((from + k) % 4)) & 1) return (from + k) % 4;
      return 0;
   endfunction

   task automatic conclude();
      $display("Counts: tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================
   // Bus transactions
   task automatic wr_cfg(input logic [6:0] a, input logic [7:0] d, input logic exp_ack);
      logic [7:0] rx;
      logic ack;
      int p;
      p = pw_cnt;
      isac_bus_master_inst.start();
      isac_bus_master_inst.xbyte({a, 1'b0}, 1'b1, rx, ack);
      `CHK("write addr ack", ~exp_ack, ack)
      if (exp_ack) begin
         isac_bus_master_inst.xbyte(d, 1'b1, rx, ack);
         `CHK("data ack", 1'b0, ack)
         cfg = d;
         cur = 0;
      end
      isac_bus_master_inst.stop();
      `CHK("power during write", p, pw_cnt)
      if (exp_ack) `CHK("ref select", d[REF_BIT], ref_ext)
   endtask

   task automatic rd_words(input int n);
      logic [7:0] hi, lo;
      logic ack;
      int p, t, ch;
      logic [CODE_W-1:0] ex;
      p = pw_cnt;
      t = trk_cnt;
      isac_bus_master_inst.start();
      isac_bus_master_inst.xbyte({ADDR_VAR1, 1'b1}, 1'b1, hi, ack);
      `CHK("read addr ack", 1'b0, ack)
      for (int i = 0; i < n; i++) begin
         ch = pick(cfg, cur);
         cur = (ch + 1) % 4;
         ex = ain[ch];
         isac_bus_master_inst.xbyte(8'hff, 1'b0, hi, ack);
         isac_bus_master_inst.xbyte(8'hff, i == n - 1, lo, ack);
         `CHK("word channel", ch[1:0], hi[5:4])
         `CHK("word code", ex, {hi[3:0], lo})
         `CHK("header pad", HDR_PAD, hi[7:6])
      end
      isac_bus_master_inst.stop();
      `CHK("power cycles", p + (WAKE_CYC + CONV_CYC) * n, pw_cnt)
      `CHK("convert cycles", t + CONV_CYC * n, trk_cnt)
      `CHK("power down after", 1'b0, pwr)
   endtask

   // ==========================================
   // Main sequence
   initial begin
      for (int k = 0; k < 4; k++) ain[k] = 12'h000;
      repeat (6) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      #1;
      `CHK("power at start", 1'b0, pwr)
      `CHK("track at start", 1'b1, trk)
      `CHK("oe at start", 1'b0, o_sda_oe)
      `CHK("data out level", 1'b0, o_sda_out)
      repeat (6) @(posedge i_clk);
      wr_cfg(ADDR_VAR0, 8'h10, 1'b0);
      ain[1] <= 12'hfff;
      rd_words(2);
      $display("test address and reset config done");
      for (int j = 0; j < 6; j++) begin
         wr_cfg(ADDR_VAR1, cfgs[j], 1'b1);
         for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            ain[k] <= lfsr[11:0];
         end
         scramble <= (j == 0);
         @(posedge i_clk);
         rd_words(nw[j]);
         $display("test config %0h done", cfgs[j]);
      end
      // Clock spike in the first address bit: swallowed, then taken as a bit
      fork
         wr_cfg(ADDR_VAR1, 8'h14, 1'b1);
         begin
            repeat (13) @(posedge i_clk);
            isac_bus_master_inst.spike();
         end
      join
      fork
         wr_cfg(ADDR_VAR1, 8'h10, 1'b0);
         begin
            repeat (13) @(posedge i_clk);
            isac_bus_master_inst.spike();
         end
      join
      $display("test line filter done");
      conclude();
   end

   initial begin
      repeat (60000) @(posedge i_clk);
      fail_count++;
      $display("ERROR watchdog expected finish seen hang");
      conclude();
   end
endmodule
`default_nettype wire

// ---- core/isac_fifo2.sv ----
// Small result buffer with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module isac_fifo2
   import isac_pkg::*;
#(
   parameter int W = CODE_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_reset,
   isac_stream_if.snk s_in,
   isac_stream_if.src s_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [W-1:0] mem_ff [DEPTH];
   logic [W-1:0] nxt_mem [DEPTH];
   logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
   logic [CW-1:0] n_ff, nxt_n;
   logic do_wr, do_rd;

   assign s_in.ready = (n_ff != CW'(DEPTH));
   assign s_out.valid = (n_ff != '0);
   assign s_out.data = mem_ff[rp_ff];

   always_comb begin
      do_wr = s_in.valid && s_in.ready;
      do_rd = s_out.valid && s_out.ready;
      nxt_mem = mem_ff;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      if (do_wr) begin
         nxt_mem[wp_ff] = s_in.data;
         nxt_wp = (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + AW'(1);
      end
      if (do_rd) begin
         nxt_rp = (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + AW'(1);
      end
      nxt_n = n_ff + CW'(do_wr) - CW'(do_rd);
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         wp_ff <= '0;
         rp_ff <= '0;
         n_ff <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
      end else begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         n_ff <= nxt_n;
         mem_ff <= nxt_mem;
      end
   end
endmodule
`default_nettype wire

// ---- core/isac_line_filter.sv ----
// Pin synchroniser and glitch filter for the two bus lines
`timescale 1ns/1ns
`default_nettype none
module isac_line_filter
   import isac_pkg::*;
#(
   parameter int N = 2,
   parameter int STABLE = FILT_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [N-1:0] i_lines,
   input wire logic i_bypass,
   output logic [N-1:0] o_lines
);
   logic [N-1:0] meta_ff;
   logic [N-1:0] sync_ff;
   logic [N-1:0] out_ff;
   logic [N-1:0] nxt_out;
   logic [FILT_CNT_W-1:0] cnt_ff [N];
   logic [FILT_CNT_W-1:0] nxt_cnt [N];

   // Unless bypassed, a level change passes only after STABLE steady cycles
   always_comb begin
      for (int i = 0; i < N; i++) begin
         nxt_cnt[i] = '0;
         nxt_out[i] = out_ff[i];
         if (i_bypass) begin
            nxt_out[i] = sync_ff[i];
         end else if (sync_ff[i] != out_ff[i]) begin
            nxt_cnt[i] = cnt_ff[i] + FILT_CNT_W'(1);
            if (cnt_ff[i] == FILT_CNT_W'(STABLE - 1)) begin
               nxt_out[i] = sync_ff[i];
               nxt_cnt[i] = '0;
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         meta_ff <= '1;
         sync_ff <= '1;
         out_ff <= '1;
         for (int i = 0; i < N; i++) begin
            cnt_ff[i] <= '0;
         end
      end else begin
         meta_ff <= i_lines;
         sync_ff <= meta_ff;
         out_ff <= nxt_out;
         cnt_ff <= nxt_cnt;
      end
   end

   assign o_lines = out_ff;
endmodule
`default_nettype wire

// ---- core/isac_top.sv ----
// Two-wire slave front end and SAR conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module isac_top
   import isac_pkg::*;
#(
   parameter logic VARIANT = 1'b0,
   parameter int STABLE = FILT_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_scl,
   input wire logic i_sda_in,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic i_comp_high,
   output logic o_adc_power_on,
   output logic o_track,
   output logic [1:0] o_mux_sel,
   output logic o_ref_ext,
   output logic [CODE_W-1:0] o_dac_code
);
   localparam logic [6:0] MY_ADDR = VARIANT ? ADDR_VAR1 : ADDR_VAR0;

   // ==========================================================
   // Line conditioning
   logic [1:0] line_f;
   logic scl, sda, scl_d_ff, sda_d_ff;
   logic scl_rise, scl_fall, start, stop;
   logic [7:0] cfg_ff, nxt_cfg;

   isac_line_filter #(.N(2), .STABLE(STABLE)) u_filt (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_lines({i_scl, i_sda_in}),
      .i_bypass(cfg_ff[FLT_BIT]),
      .o_lines(line_f)
   );

   assign scl = line_f[1];
   assign sda = line_f[0];
   // Edges found from samples, so the bus must run several clock cycles per line level
   assign scl_rise = scl && !scl_d_ff;
   assign scl_fall = !scl && scl_d_ff;
   assign start = scl && scl_d_ff && sda_d_ff && !sda;
   assign stop = scl && scl_d_ff && !sda_d_ff && sda;

   // ==========================================================
   // Channel choice
   logic [3:0] eff_sel;
   logic [1:0] next_ch, last_ff, nxt_last;
   logic first_ff, nxt_first;

   function automatic logic [1:0] pick_chan(input logic [3:0] sel, input logic [1:0] last,
                                            input logic first);
      logic [1:0] idx;
      logic [1:0] res;
      logic found;
      res = 2'h0;
      found = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         idx = first ? 2'(i) : last + 2'(i + 1);
         if (!found && sel[idx]) begin
            res = idx;
            found = 1'b1;
         end
      end
      return res;
   endfunction

   // External reference takes over the fourth input
   assign eff_sel = cfg_ff[CFG_CH_LSB +: 4] & (cfg_ff[REF_BIT] ? EXT_REF_MASK : 4'hf);
   assign next_ch = pick_chan(eff_sel, last_ff, first_ff);

   // ==========================================================
   // Result buffer
   isac_stream_if #(.W(CODE_W)) fifo_in ();
   isac_stream_if #(.W(CODE_W)) fifo_out ();
   logic pop;

   isac_fifo2 #(.W(CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .s_in(fifo_in),
      .s_out(fifo_out)
   );
   assign fifo_out.ready = pop;

   // ==========================================================
   // Bus slave
   isac_bus_state_type st_ff, nxt_st;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] rx_ff, nxt_rx;
   logic [15:0] tx_ff, nxt_tx;
   logic oe_ff, nxt_oe, lo_ff, nxt_lo, mack_ff, nxt_mack;
   logic conv_go, cfg_wr;

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_rx = rx_ff;
      nxt_tx = tx_ff;
      nxt_oe = oe_ff;
      nxt_cfg = cfg_ff;
      nxt_lo = lo_ff;
      nxt_mack = mack_ff;
      conv_go = 1'b0;
      cfg_wr = 1'b0;
      pop = 1'b0;
      if (stop) begin
         nxt_st = BS_IDLE;
         nxt_oe = 1'b0;
      end else if (start) begin
         nxt_st = BS_ADDR;
         nxt_cnt = '0;
         nxt_oe = 1'b0;
      end else begin
         unique case (st_ff)
            BS_IDLE: begin
               nxt_oe = 1'b0;
            end
            BS_ADDR, BS_WDAT: begin
               if (scl_rise) begin
                  nxt_rx = {rx_ff[6:0], sda};
                  nxt_cnt = cnt_ff + 4'h1;
               end
               if (scl_fall && cnt_ff == 4'h8) begin
                  nxt_cnt = '0;
                  if (st_ff == BS_WDAT) begin
                     // Write lands whatever the converter is doing
                     nxt_cfg = rx_ff;
                     cfg_wr = 1'b1;
                     nxt_oe = 1'b1;
                     nxt_st = BS_WACK;
                  end else if (rx_ff[7:1] == MY_ADDR) begin
                     nxt_oe = 1'b1;
                     nxt_lo = 1'b0;
                     nxt_st = BS_AACK;
                     if (rx_ff[0]) begin
                        conv_go = 1'b1;
                        nxt_tx = {HDR_PAD, next_ch, TX_FILL};
                     end
                  end else begin
                     nxt_st = BS_IDLE;
                  end
               end
            end
            BS_AACK, BS_WACK: begin
               if (scl_fall) begin
                  nxt_st = (st_ff == BS_AACK && rx_ff[0]) ? BS_RDAT : BS_WDAT;
                  nxt_oe = (nxt_st == BS_RDAT) && !tx_ff[15];
               end
            end
            BS_RDAT: begin
               if (scl_fall) begin
                  nxt_cnt = cnt_ff + 4'h1;
                  if (cnt_ff == 4'h7) begin
                     nxt_tx = tx_ff << 1;
                     nxt_oe = 1'b0;
                     nxt_st = BS_RACK;
                  end else if (!lo_ff && cnt_ff == 4'h3) begin
                     // Code bits are taken from the buffer only when needed
                     pop = 1'b1;
                     nxt_tx = fifo_out.valid ? {fifo_out.data, 4'h0} : tx_ff << 1;
                     nxt_oe = !nxt_tx[15];
                  end else begin
                     nxt_tx = tx_ff << 1;
                     nxt_oe = !nxt_tx[15];
                  end
               end
            end
            BS_RACK: begin
               if (scl_rise) begin
                  nxt_mack = !sda;
               end
               if (scl_fall) begin
                  nxt_cnt = '0;
                  if (mack_ff) begin
                     nxt_st = BS_RDAT;
                     nxt_lo = !lo_ff;
                     if (lo_ff) begin
                        conv_go = 1'b1;
                        nxt_tx = {HDR_PAD, next_ch, TX_FILL};
                     end
                     nxt_oe = !nxt_tx[15];
                  end else begin
                     nxt_st = BS_IDLE;
                  end
               end
            end
            default: begin
               nxt_st = BS_IDLE;
               nxt_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st_ff <= BS_IDLE;
         cnt_ff <= '0;
         rx_ff <= '0;
         tx_ff <= '1;
         oe_ff <= 1'b0;
         cfg_ff <= CFG_RESET;
         lo_ff <= 1'b0;
         mack_ff <= 1'b0;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         rx_ff <= nxt_rx;
         tx_ff <= nxt_tx;
         oe_ff <= nxt_oe;
         cfg_ff <= nxt_cfg;
         lo_ff <= nxt_lo;
         mack_ff <= nxt_mack;
         scl_d_ff <= scl;
         sda_d_ff <= sda;
      end
   end

   // Only ever pulls low
   assign o_sda_out = 1'b0;
   assign o_sda_oe = oe_ff;

   // ==========================================================
   // Conversion sequencer
   isac_conv_state_type cst_ff, nxt_cst;
   logic [CNT_W-1:0] ccnt_ff, nxt_ccnt;
   logic [CODE_W-1:0] mask_ff, nxt_mask, dac_ff, nxt_dac;
   logic [1:0] mux_ff, nxt_mux;

   always_comb begin
      nxt_cst = cst_ff;
      nxt_ccnt = ccnt_ff;
      nxt_mask = mask_ff;
      nxt_dac = dac_ff;
      nxt_mux = mux_ff;
      nxt_last = last_ff;
      nxt_first = first_ff;
      if (cfg_wr) begin
         nxt_first = 1'b1;
      end
      unique case (cst_ff)
         CS_PD: begin
            if (conv_go) begin
               nxt_cst = CS_WAKE;
               nxt_ccnt = '0;
               nxt_mux = next_ch;
               nxt_last = next_ch;
               nxt_first = 1'b0;
            end
         end
         CS_WAKE: begin
            nxt_ccnt = ccnt_ff + CNT_W'(1);
            if (ccnt_ff == CNT_W'(WAKE_CYC - 1)) begin
               nxt_cst = CS_CONV;
               nxt_ccnt = '0;
               nxt_mask = SAR_MSB;
               nxt_dac = SAR_MSB;
            end
         end
         CS_CONV: begin
            // Keep the trial bit when the input is above the DAC level
            nxt_ccnt = ccnt_ff + CNT_W'(1);
            nxt_mask = mask_ff >> 1;
            nxt_dac = (i_comp_high ? dac_ff : dac_ff & ~mask_ff) | (mask_ff >> 1);
            if (ccnt_ff == CNT_W'(CONV_CYC - 1)) begin
               nxt_cst = CS_PUSH;
            end
         end
         CS_PUSH: begin
            if (fifo_in.ready) begin
               nxt_cst = CS_PD;
            end
         end
         default: begin
            nxt_cst = CS_PD;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cst_ff <= CS_PD;
         ccnt_ff <= '0;
         mask_ff <= '0;
         dac_ff <= '0;
         mux_ff <= '0;
         last_ff <= '0;
         first_ff <= 1'b1;
      end else begin
         cst_ff <= nxt_cst;
         ccnt_ff <= nxt_ccnt;
         mask_ff <= nxt_mask;
         dac_ff <= nxt_dac;
         mux_ff <= nxt_mux;
         last_ff <= nxt_last;
         first_ff <= nxt_first;
      end
   end

   assign fifo_in.valid = (cst_ff == CS_PUSH);
   assign fifo_in.data = dac_ff;
   assign o_adc_power_on = (cst_ff == CS_WAKE) || (cst_ff == CS_CONV);
   assign o_track = (cst_ff != CS_CONV);
   assign o_mux_sel = mux_ff;
   assign o_ref_ext = cfg_ff[REF_BIT];
   assign o_dac_code = dac_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence s_wake;
      o_track [*8] ##1 o_track ##1 o_track ##1 !o_track;
   endsequence
   sequence s_conv;
      ##19 o_adc_power_on ##1 !o_adc_power_on;
   endsequence

   property p_addr;
      (st_ff == BS_AACK && $past(st_ff) == BS_ADDR) |-> $past(rx_ff[7:1]) == MY_ADDR;
   endproperty
   a_addr: assert property (p_addr) else $error("ack to foreign address");
   property p_drain;
      o_sda_oe |-> !o_sda_out && (st_ff inside {BS_AACK, BS_WACK, BS_RDAT});
   endproperty
   a_drain: assert property (p_drain) else $error("data line driven out of turn");
   property p_start_pd;
      $past(i_reset) |-> cst_ff == CS_PD && !o_adc_power_on;
   endproperty
   a_start_pd: assert property (p_start_pd) else $error("not powered down after reset");
   property p_go;
      (conv_go && cst_ff == CS_PD) |=> o_adc_power_on && o_mux_sel == $past(next_ch);
   endproperty
   a_go: assert property (p_go) else $error("conversion did not power up");
   property p_cfg;
      (st_ff == BS_WACK && $past(st_ff) == BS_WDAT) |-> cfg_ff == $past(rx_ff);
   endproperty
   a_cfg: assert property (p_cfg) else $error("configuration byte lost");
   property p_wake;
      $rose(o_adc_power_on) |-> s_wake;
   endproperty
   a_wake: assert property (p_wake) else $error("wake-up interval wrong");
   property p_conv;
      $fell(o_track) |-> s_conv;
   endproperty
   a_conv: assert property (p_conv) else $error("conversion time wrong");
   property p_hold;
      (cst_ff == CS_CONV) |-> !o_track && $stable(o_mux_sel);
   endproperty
   a_hold: assert property (p_hold) else $error("input not held during conversion");
   property p_sar;
      (cst_ff == CS_CONV && mask_ff != '0 && !i_comp_high) |=> (dac_ff & $past(mask_ff)) == '0;
   endproperty
   a_sar: assert property (p_sar) else $error("rejected trial bit kept");
   property p_code;
      (pop && fifo_out.valid) |=> tx_ff == {$past(fifo_out.data), 4'h0};
   endproperty
   a_code: assert property (p_code) else $error("code not sent as converted");
   property p_ref;
      ($rose(o_adc_power_on) && o_ref_ext) |-> o_mux_sel != CH_EXT;
   endproperty
   a_ref: assert property (p_ref) else $error("reference pin converted");
   property p_read;
      (st_ff == BS_AACK && $past(st_ff) == BS_ADDR && rx_ff[0] && $past(cst_ff) == CS_PD)
         |-> o_adc_power_on;
   endproperty
   a_read: assert property (p_read) else $error("read did not start conversion");
endmodule
`default_nettype wire

// ---- include/isac_pkg.sv ----
// Constants and types for the two-wire SAR converter controller
// Summary of operation
// - Answers as slave at 7-bit address 0x28, or 0x29 in the second variant.
// - Clock line is input only; data line is only pulled low, open-drain.
// - Comes out of reset in the power-down state.
// - Powers up before each conversion and powers down once it completes.
// - Bus writes complete while powered down; a read powers up for its conversion, no wake command.
// - Allows about 1 us wake-up before each conversion starts.
// - One conversion takes about 2 us after the wake-up interval.
// - Input is disconnected from the sampling capacitor when conversion begins.
// - Successive approximation steps the DAC, then control logic forms the code.
// - Output is straight binary; one LSB is reference over 4096.
// - Supply reference gives four channels; external reference gives three.
// - One of four single-ended inputs is routed to the track-and-hold.
// - Standard, fast and high-speed bus modes work with either variant.
// - Several selected channels convert in turn, lowest first.
// - Reference bit 0 selects supply, 1 selects external reference pin.
// - Filter bit 0 keeps line glitch filtering, 1 bypasses it.
package isac_pkg;
   localparam logic [6:0] ADDR_VAR0 = 7'h28;
   localparam logic [6:0] ADDR_VAR1 = 7'h29;
   localparam int CLK_NS = 100;
   localparam int WAKE_NS = 1000;
   localparam int CONV_NS = 2000;
   localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 5;
   localparam int CODE_W = 12;
   localparam logic [CODE_W-1:0] SAR_MSB = 12'h800;
   localparam logic [CODE_W-1:0] TX_FILL = 12'hfff;
   localparam logic [1:0] HDR_PAD = 2'h0;
   localparam int NUM_CH = 4;
   localparam logic [1:0] CH_EXT = 2'h3;
   localparam logic [3:0] EXT_REF_MASK = 4'h7;
   localparam logic [7:0] CFG_RESET = 8'hf0;
   localparam int CFG_CH_LSB = 4;
   localparam int REF_BIT = 3;
   localparam int FLT_BIT = 2;
   localparam int FILT_CYC = 2;
   localparam int FILT_CNT_W = 4;
   localparam int FIFO_DEPTH = 2;
   typedef enum logic [6:0] {
      BS_IDLE = 7'h01,
      BS_ADDR = 7'h02,
      BS_AACK = 7'h04,
      BS_WDAT = 7'h08,
      BS_WACK = 7'h10,
      BS_RDAT = 7'h20,
      BS_RACK = 7'h40
   } isac_bus_state_type;
   typedef enum logic [3:0] {
      CS_PD = 4'h1,
      CS_WAKE = 4'h2,
      CS_CONV = 4'h4,
      CS_PUSH = 4'h8
   } isac_conv_state_type;
endpackage

// ---- include/isac_stream_if.sv ----
// Valid/ready word stream between the converter and its result buffer
`timescale 1ns/1ns
`default_nettype none
interface isac_stream_if #(parameter int W = 12) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire
